// *** swf_core.sv ***
`timescale 1ns/1ps
module swf_core
  import swf_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // instruction from fetch
  input  wire logic              opValid,
  input  wire logic [OP_W-1:0]   opcode,
  // addressing context
  input  wire logic              extEnable,
  input  wire logic [3:0]        bankSelect,
  input  wire logic [ADDR_W-1:0] indexBase,
  // data memory
  input  wire logic [DATA_W-1:0] memRdData,
  output swf_mem_req_t           memReq,
  // core state
  output logic      [DATA_W-1:0] wReg,
  output swf_flags_t             status,
  output swf_phase_t             phase,
  output logic                   opDone
);

  function automatic logic isLitOp(input logic [OP_W-1:0] op);
    return op[15:8] == LIT_OP_HI;
  endfunction

  function automatic logic isFileOp(input logic [OP_W-1:0] op);
    return op[15:10] == FILE_OP_HI;
  endfunction

  // file address from operand, access bit and context
  function automatic logic [ADDR_W-1:0] mapAddr(input logic [7:0] f,
                                                input logic a,
                                                input logic ext,
                                                input logic [3:0] bank,
                                                input logic [ADDR_W-1:0] base);
    if (a) begin
      return {bank, f};
    end else if (ext && (f <= ACCESS_SPLIT)) begin
      return base + {4'h0, f};
    end else if (f <= ACCESS_SPLIT) begin
      return {ACC_LO_BANK, f};
    end else begin
      return {ACC_HI_BANK, f};
    end
  endfunction

  logic              curLit;
  logic              curFile;
  logic              curDest;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] aluDiff;
  swf_flags_t        aluFlags;
  logic              accept;

  assign accept = (phase == PH_Q1) && opValid && (isLitOp(opcode) || isFileOp(opcode));

  swf_alu u_swf_alu (
    .minuend    (operand),
    .subtrahend (wReg),
    .diff       (aluDiff),
    .flags      (aluFlags)
  );

  // free running four-phase sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= PH_Q1;
    end else begin
      case (phase)
        PH_Q1: phase <= PH_Q2;
        PH_Q2: phase <= PH_Q3;
        PH_Q3: phase <= PH_Q4;
        default: phase <= PH_Q1;
      endcase
    end
  end

  // q1 decode: only the two subtracts are taken, others idle a cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      curLit  <= 1'b0;
      curFile <= 1'b0;
      curDest <= 1'b0;
    end else if (phase == PH_Q1) begin
      curLit  <= opValid && isLitOp(opcode);
      curFile <= opValid && isFileOp(opcode);
      curDest <= opcode[DEST_BIT];
    end
  end

  // operand: literal at decode, file data sampled at end of q2
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      operand <= W_RESET;
    end else if (phase == PH_Q1) begin
      operand <= opcode[7:0];
    end else if ((phase == PH_Q2) && curFile) begin
      operand <= memRdData;
    end
  end

  // memory port: read during q2, write during q4
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      memReq <= MEM_REQ_RESET;
    end else begin
      case (phase)
        PH_Q1: begin
          memReq.rd   <= opValid && isFileOp(opcode);
          memReq.wr   <= 1'b0;
          memReq.addr <= mapAddr(opcode[7:0], opcode[ACCESS_BIT], extEnable,
                                 bankSelect, indexBase);
        end
        PH_Q3: begin
          memReq.rd    <= 1'b0;
          memReq.wr    <= curFile && curDest;
          memReq.wdata <= aluDiff;
        end
        default: begin
          memReq.rd <= 1'b0;
          memReq.wr <= 1'b0;
        end
      endcase
    end
  end

  // q3 compute: result held and flags updated together
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      result <= W_RESET;
      status <= FLAGS_RESET;
    end else if ((phase == PH_Q3) && (curLit || curFile)) begin
      result <= aluDiff;
      status <= aluFlags;
    end
  end

  // q4 write: working register takes the result unless routed to file
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wReg <= W_RESET;
    end else if ((phase == PH_Q4) && (curLit || (curFile && !curDest))) begin
      wReg <= result;
    end
  end

  // completion pulse in the q1 after each subtract
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      opDone <= 1'b0;
    end else begin
      opDone <= (phase == PH_Q4) && (curLit || curFile);
    end
  end

  // checks
  property p_phase_order;
    @(posedge sys_clk) disable iff (!nrst)
      (phase == PH_Q1) |=> (phase == PH_Q2) ##1 (phase == PH_Q3) ##1 (phase == PH_Q4);
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("phases out of order");

  property p_one_cycle;
    @(posedge sys_clk) disable iff (!nrst)
      accept |-> ##1 !opDone [*3] ##1 opDone;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("subtract did not finish in one instruction cycle");

  property p_lit_result;
    @(posedge sys_clk) disable iff (!nrst)
      (accept && isLitOp(opcode)) |-> ##4 (wReg == 8'($past(opcode[7:0], 4) - $past(wReg, 4)));
  endproperty
  a_lit_result: assert property (p_lit_result)
    else $error("literal subtract wrong working value");

  property p_file_read;
    @(posedge sys_clk) disable iff (!nrst)
      (accept && isFileOp(opcode)) |=> memReq.rd && !memReq.wr;
  endproperty
  a_file_read: assert property (p_file_read)
    else $error("file operand not read in q2");

  property p_file_to_file;
    @(posedge sys_clk) disable iff (!nrst)
      (accept && isFileOp(opcode) && opcode[DEST_BIT]) |-> ##3
        (memReq.wr && (memReq.wdata == 8'($past(memRdData, 2) - wReg)));
  endproperty
  a_file_to_file: assert property (p_file_to_file)
    else $error("file destination write wrong");

  property p_file_to_w;
    @(posedge sys_clk) disable iff (!nrst)
      (accept && isFileOp(opcode) && !opcode[DEST_BIT]) |-> ##3 !memReq.wr
        ##1 (wReg == 8'($past(memRdData, 3) - $past(wReg, 4)));
  endproperty
  a_file_to_w: assert property (p_file_to_w)
    else $error("working destination wrong");

  property p_bank_sel;
    @(posedge sys_clk) disable iff (!nrst)
      (accept && isFileOp(opcode) && opcode[ACCESS_BIT]) |=>
        (memReq.addr == {$past(bankSelect), $past(opcode[7:0])});
  endproperty
  a_bank_sel: assert property (p_bank_sel)
    else $error("banked address wrong");

  property p_indexed;
    @(posedge sys_clk) disable iff (!nrst)
      (accept && isFileOp(opcode) && !opcode[ACCESS_BIT] && extEnable &&
       (opcode[7:0] <= ACCESS_SPLIT)) |=>
        (memReq.addr == 12'($past(indexBase) + {4'h0, $past(opcode[7:0])}));
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed offset address wrong");

  property p_flags;
    @(posedge sys_clk) disable iff (!nrst)
      (accept && isLitOp(opcode)) |-> ##3
        (status.c == ($past(opcode[7:0], 3) >= wReg)) &&
        (status.z == ($past(opcode[7:0], 3) == wReg)) &&
        (status.n == ((($past(opcode[7:0], 3) - wReg) & 8'h80) != 8'h00));
  endproperty
  a_flags: assert property (p_flags)
    else $error("carry zero or negative flag wrong");

  property p_overflow_digit;
    @(posedge sys_clk) disable iff (!nrst)
      (accept && isLitOp(opcode)) |-> ##3
        (status.digitCarry == ($past(opcode[3:0], 3) >= wReg[3:0])) &&
        (status.overflow == (($past(opcode[7], 3) != wReg[7]) &&
                             (status.n != $past(opcode[7], 3))));
  endproperty
  a_overflow_digit: assert property (p_overflow_digit)
    else $error("overflow or digit carry wrong");

endmodule // swf_core

// *** swf_pkg.sv ***
`timescale 1ns/1ps
package swf_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 12;
  localparam int          OP_W         = 16;
  // opcode patterns in the upper bits
  localparam logic [7:0]  LIT_OP_HI    = 8'h08;
  localparam logic [5:0]  FILE_OP_HI   = 6'h17;
  localparam int          DEST_BIT     = 9;
  localparam int          ACCESS_BIT   = 8;
  // access bank split: 00 to 5f is ram, 60 to ff special registers
  localparam logic [7:0]  ACCESS_SPLIT = 8'h5f;
  localparam logic [3:0]  ACC_LO_BANK  = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK  = 4'hf;
  localparam logic [7:0]  W_RESET      = 8'h00;
  localparam logic [11:0] ADDR_RESET   = 12'h000;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } swf_phase_t;

  typedef struct packed {
    logic n;
    logic overflow;
    logic z;
    logic digitCarry;
    logic c;
  } swf_flags_t;

  localparam swf_flags_t FLAGS_RESET = 5'h00;

  // data memory request as seen by the register file
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } swf_mem_req_t;

  localparam swf_mem_req_t MEM_REQ_RESET = 22'h000000;
endpackage

// borrow-ripple subtractor: minuend minus subtrahend with flags
module swf_alu
  import swf_pkg::*;
(
  // operands
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  // results
  output logic      [DATA_W-1:0] diff,
  output swf_flags_t             flags
);
  logic [DATA_W:0] borrow;

  assign borrow[0] = 1'b0;
  // ripple chain exposes the bit 3 borrow for digit carry
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_bit
      assign diff[i]     = minuend[i] ^ subtrahend[i] ^ borrow[i];
      assign borrow[i+1] = (~minuend[i] & subtrahend[i]) |
                           (~(minuend[i] ^ subtrahend[i]) & borrow[i]);
    end
  endgenerate

  // flags from the same chain
  assign flags.c  = ~borrow[DATA_W];
  assign flags.digitCarry = ~borrow[4];
  assign flags.z  = (diff == 8'h00);
  assign flags.n  = diff[DATA_W-1];
  assign flags.overflow = (minuend[DATA_W-1] != subtrahend[DATA_W-1]) &&
                          (diff[DATA_W-1] != minuend[DATA_W-1]);
endmodule // swf_alu

// *** test_subtract_w_instructions.sv ***
`timescale 1ns/1ps
module test_subtract_w_instructions;
  import swf_pkg::*;
  typedef struct packed {
    logic [15:0] op;
    logic        ext;
    logic [3:0]  bank;
    logic [11:0] base;
    logic [7:0]  rd;
    logic [7:0]  res;
    swf_flags_t  fl;
    logic [11:0] addr;
  } swf_row_t;
  // op, ext, bank, base, read data, difference, flags (n, overflow, z, digit carry, c), address
  localparam swf_row_t ROWS [12] = '{
    '{16'h0802, 1'h0, 4'h0, 12'h000, 8'h00, 8'h02, 5'h03, 12'h000},
    '{16'h0802, 1'h0, 4'h0, 12'h000, 8'h00, 8'h00, 5'h07, 12'h000},
    '{16'h0803, 1'h0, 4'h0, 12'h000, 8'h00, 8'h03, 5'h03, 12'h000},
    '{16'h0802, 1'h0, 4'h0, 12'h000, 8'h00, 8'hff, 5'h10, 12'h000},
    '{16'h087f, 1'h0, 4'h0, 12'h000, 8'h00, 8'h80, 5'h1a, 12'h000},
    '{16'h5d12, 1'h0, 4'h3, 12'h000, 8'h90, 8'h10, 5'h03, 12'h312},
    '{16'h5e60, 1'h0, 4'h0, 12'h000, 8'h0f, 8'hff, 5'h12, 12'hf60},
    '{16'h5e5f, 1'h0, 4'h0, 12'h000, 8'h10, 8'h00, 5'h07, 12'h05f},
    '{16'h5c5f, 1'h1, 4'h0, 12'hff0, 8'h20, 8'h10, 5'h03, 12'h04f},
    '{16'h5c60, 1'h1, 4'h0, 12'hff0, 8'h21, 8'h11, 5'h03, 12'hf60},
    '{16'h5f00, 1'h1, 4'hf, 12'h000, 8'h01, 8'hf0, 5'h12, 12'hf00},
    '{16'h0880, 1'h0, 4'h0, 12'h000, 8'h00, 8'h6f, 5'h09, 12'h000}};

  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              opValid = 1'b0;
  logic [OP_W-1:0]   opcode = 16'h0000;
  logic              extEnable = 1'b0;
  logic [3:0]        bankSelect = 4'h0;
  logic [ADDR_W-1:0] indexBase = 12'h000;
  logic [DATA_W-1:0] memRdData = 8'h00;
  swf_mem_req_t      memReq;
  logic [DATA_W-1:0] wReg;
  swf_flags_t        status;
  swf_phase_t        phase;
  logic              opDone;
  int                err_count = 0;
  int                checks = 0;
  int                cycles = 0;
  logic [7:0]        curW = 8'h00;
  logic              isFile;

  swf_core u_swf_core (
    .sys_clk(sys_clk), .nrst(nrst), .opValid(opValid), .opcode(opcode),
    .extEnable(extEnable), .bankSelect(bankSelect), .indexBase(indexBase),
    .memRdData(memRdData), .memReq(memReq), .wReg(wReg), .status(status),
    .phase(phase), .opDone(opDone));

  // 100 ns period
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard, well above the roughly 80 cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      err_count++;
      $display("ERROR %0t timeout", $time);
      complete_run();
    end
  end

  task automatic fail(input string msg);
    err_count++;
    $display("ERROR %0t %0s", $time, msg);
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("byte %h exp %h", got, exp));
  endtask
  task automatic cmp_flags(input swf_flags_t got, input swf_flags_t exp);
    checks++;
    if (got !== exp) fail($sformatf("flags %b exp %b", got, exp));
  endtask
  task automatic cmp_addr(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("addr %h exp %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail($sformatf("bit %b exp %b", got, exp));
  endtask

  // reset state of every output but memReq.wdata
  task automatic check_reset();
    cmp_byte(wReg, W_RESET);
    cmp_flags(status, FLAGS_RESET);
    cmp_bit(phase === PH_Q1, 1'b1);
    cmp_bit(memReq.rd, 1'b0);
    cmp_bit(memReq.wr, 1'b0);
    cmp_addr(memReq.addr, ADDR_RESET);
    cmp_bit(opDone, 1'b0);
  endtask

  task automatic wait_q1();
    while (phase !== PH_Q1) @(negedge sys_clk);
  endtask

  // one instruction through all four phases; leaves off at the next q1
  task automatic run_row(input swf_row_t r);
    wait_q1();
    isFile = (r.op[15:10] == FILE_OP_HI);
    opValid = 1'b1;
    opcode = r.op;
    extEnable = r.ext;
    bankSelect = r.bank;
    indexBase = r.base;
    memRdData = r.rd;
    @(negedge sys_clk);
    opValid = 1'b0;
    cmp_bit(memReq.rd, isFile);
    if (isFile) cmp_addr(memReq.addr, r.addr);
    repeat (2) @(negedge sys_clk);
    cmp_flags(status, r.fl);
    cmp_bit(memReq.wr, isFile && r.op[DEST_BIT]);
    if (isFile && r.op[DEST_BIT]) cmp_byte(memReq.wdata, r.res);
    cmp_bit(opDone, 1'b0);
    if (!(isFile && r.op[DEST_BIT])) curW = r.res;
    @(negedge sys_clk);
    cmp_byte(wReg, curW);
    cmp_bit(opDone, 1'b1);
  endtask

  // request that must leave wReg and status alone, raise no opDone and start no read
  task automatic ignored(input logic inQ1, input logic [15:0] op);
    swf_flags_t keep;
    keep = status;
    wait_q1();
    if (!inQ1) @(negedge sys_clk);
    opValid = 1'b1;
    opcode = op;
    @(negedge sys_clk);
    opValid = 1'b0;
    cmp_bit(memReq.rd, 1'b0);
    repeat (5) begin
      @(negedge sys_clk);
      cmp_bit(opDone, 1'b0);
    end
    cmp_byte(wReg, curW);
    cmp_flags(status, keep);
    $display("test ignored op %h done", op);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge sys_clk);
    check_reset();
    nrst = 1'b1;
    $display("test reset done");
    // back to back, each row issued in the q1 that shows the last result
    foreach (ROWS[i]) run_row(ROWS[i]);
    $display("test table done");
    ignored(1'b0, 16'h0801);
    // neighbouring borrow subtract encoding is not ours
    ignored(1'b1, 16'h5a12);
    // reset in mid-instruction drops the pending result
    wait_q1();
    opValid = 1'b1;
    opcode = 16'h0844;
    repeat (3) @(negedge sys_clk);
    opValid = 1'b0;
    nrst = 1'b0;
    @(negedge sys_clk);
    check_reset();
    nrst = 1'b1;
    curW = W_RESET;
    run_row(ROWS[0]);
    $display("test mid reset done");
    complete_run();
  end
endmodule // test_subtract_w_instructions
